//--- mcc_defines.vh
// constants for the memory crc check engine
// guarded for more than one includer; plain verilog-2005, no process or assignment here
//
// Functional notes
// - checksum is crc-64 ecma: reflected polynomial, all-ones seed, inverted result
// - computed code is compared with the 64-bit expected value from the command
// - pass or fail shows as flag status bit 3, one meaning fail
// - on fail the computed code lands in the readback buffer; never on pass
// - read-buffer command 96h returns buffer from location zero, low byte first
// - buffer clears to zero at the start of every check
// - buffer clears to zero on power-up, hardware and software reset
// - read past location 7 returns zero bytes
// - third byte ffh selects whole array, feh selects an address range
// - range bytes 12-14 start, 16-18 end, low first; 15 and 19 unused
// - check starts only when chip select rises after a complete sequence
// - interrupt status bit 1 is zero while running, one once done
// - interrupt mask bit 1 keeps completion off the interrupt output
// - range addresses apply inside the currently selected die
// - signalling-sequence reset does not abort a running check
`ifndef MCC_DEFINES_VH
`define MCC_DEFINES_VH
// ************************************************
// command bytes
// ************************************************
`define MCC_OP_ACTIVATE   8'h9b
`define MCC_OP_SUB_CRC    8'h27
`define MCC_OP_RD_BUF     8'h96
`define MCC_SCOPE_ALL     8'hff
`define MCC_SCOPE_RANGE   8'hfe
// byte positions within a sequence, counted from one
`define MCC_IDX_EXP_FIRST 5'h04
`define MCC_IDX_EXP_LAST  5'h0b
`define MCC_IDX_STA_FIRST 5'h0c
`define MCC_IDX_STA_LAST  5'h0e
`define MCC_IDX_END_FIRST 5'h10
`define MCC_IDX_END_LAST  5'h12
`define MCC_IDX_RNG_DONE  5'h13
// ************************************************
// crc and array
// ************************************************
`define MCC_CRC_POLY_REF  64'hc96c5795d7870f42
`define MCC_CRC_SEED      64'hffffffffffffffff
`define MCC_ADDR_FIRST    24'h000000
`define MCC_ADDR_LAST     24'hffffff
`define MCC_BUF_LOCS      7'h40
`define MCC_FSR_FAIL_BIT  3
`define MCC_ISR_DONE_BIT  1
`endif

//--- mcc_crc_engine.v
// memory crc check engine: serial command decode, crc-64 walk, readback buffer
// assumes a single-line spi mode 0 link sampled by clk_sys (sck well below
// clk_sys/4), and an array read port answering on the clk_sys domain
`timescale 1ns/1ns
`default_nettype none
`include "mcc_defines.vh"
module mcc_crc_engine
(
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        hw_rst_pin_n,
    input  wire        soft_rst,
    input  wire        sig_rst,
    input  wire        spi_cs_n,
    input  wire        spi_sck,
    input  wire        spi_si,
    output reg         spi_so_r,
    output reg         spi_so_oe_n_r,
    input  wire [1:0]  die_sel,
    output reg         mem_rd_r,
    output reg  [23:0] mem_addr_r,
    output reg  [1:0]  mem_die_r,
    input  wire        mem_ack,
    input  wire [7:0]  mem_rdata,
    input  wire [7:0]  int_mask,
    input  wire        done_clr,
    output reg  [7:0]  flag_status_r,
    output reg  [7:0]  int_status_r,
    output reg         irq_r,
    output reg         busy_r
);
    // ************************************************
    // functions
    // ************************************************
    // one byte through the reflected crc-64
    function [63:0] crc_byte;
        input [63:0] c;
        input [7:0]  d;
        integer      k;
        reg   [63:0] t;
        begin
            t = c ^ {56'h0, d};
            for (k = 0; k < 8; k = k + 1)
                t = t[0] ? ((t >> 1) ^ `MCC_CRC_POLY_REF) : (t >> 1);
            crc_byte = t;
        end
    endfunction

    // ************************************************
    // state encoding
    // ************************************************
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_READ = 4'h2;
    localparam [3:0] ST_GAP  = 4'h4;
    localparam [3:0] ST_FIN  = 4'h8;

    // ************************************************
    // synchronisers and edge detect
    // ************************************************
    reg  [3:0] sync1_r;
    reg  [3:0] sync2_r;
    reg        sck_prev_r;
    reg        cs_prev_r;
    wire       cs_n_s  = sync2_r[0];
    wire       sck_s   = sync2_r[1];
    wire       si_s    = sync2_r[2];
    wire       hw_rst  = ~sync2_r[3];
    wire       sck_rise = ~cs_n_s & sck_s & ~sck_prev_r;
    wire       sck_fall = ~cs_n_s & ~sck_s & sck_prev_r;
    wire       cs_rise  = cs_n_s & ~cs_prev_r;
    wire       eng_rst  = hw_rst | soft_rst;

    // two flops on every pin input
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r    <= 4'h9; // idle pin levels: reset and cs high, sck and si low
            sync2_r    <= 4'h9;
            sck_prev_r <= 1'b0;
            cs_prev_r  <= 1'b1;
        end
        else
        begin
            sync1_r    <= {hw_rst_pin_n, spi_si, spi_sck, spi_cs_n};
            sync2_r    <= sync1_r;
            sck_prev_r <= sync2_r[1];
            cs_prev_r  <= sync2_r[0];
        end
    end

    // ************************************************
    // command decoder
    // ************************************************
    reg  [7:0]  rx_sh_r;
    reg  [2:0]  bit_cnt_r;
    reg  [4:0]  byte_idx_r;
    reg         seq_ok_r;
    reg         scope_rng_r;
    reg         rd_mode_r;
    reg  [63:0] exp_r;
    reg  [23:0] sta_r;
    reg  [23:0] end_r;
    reg  [7:0]  tx_sh_r;
    reg  [6:0]  rd_loc_r;
    reg  [63:0] buf_r;
    wire [7:0]  rx_byte = {rx_sh_r[6:0], si_s};
    wire        byte_done = sck_rise & (bit_cnt_r == 3'h7);
    wire [4:0]  idx_nxt = (byte_idx_r == 5'h1f) ? byte_idx_r : byte_idx_r + 5'h01;
    wire        seq_full = seq_ok_r &
                    (scope_rng_r ? (byte_idx_r >= `MCC_IDX_RNG_DONE)
                                 : (byte_idx_r >= `MCC_IDX_EXP_LAST));
    wire [7:0]  buf_byte = (rd_loc_r < 7'h08) ? buf_r[{rd_loc_r[2:0], 3'h0} +: 8] : 8'h00;
    wire [6:0]  loc_nxt = (rd_loc_r > `MCC_BUF_LOCS) ? rd_loc_r : rd_loc_r + 7'h01;

    // shift in bytes and capture sequence fields
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_sh_r     <= 8'h00;
            bit_cnt_r   <= 3'h0;
            byte_idx_r  <= 5'h00;
            seq_ok_r    <= 1'b0;
            scope_rng_r <= 1'b0;
            rd_mode_r   <= 1'b0;
            exp_r       <= 64'h0;
            sta_r       <= 24'h0;
            end_r       <= 24'h0;
            tx_sh_r     <= 8'h00;
            rd_loc_r    <= 7'h00;
        end
        else if (eng_rst | sig_rst | cs_n_s)
        begin
            // any reset, or deselect, drops the partial sequence
            bit_cnt_r  <= 3'h0;
            byte_idx_r <= 5'h00;
            rd_mode_r  <= 1'b0;
            rd_loc_r   <= 7'h00;
            if (eng_rst | sig_rst | ~cs_rise)
                seq_ok_r <= 1'b0;
            else
                seq_ok_r <= seq_ok_r;
        end
        else
        begin
            if (sck_rise)
            begin
                rx_sh_r   <= rx_byte;
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (sck_fall)
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            if (byte_done)
            begin
                byte_idx_r <= idx_nxt;
                // byte numbers count from one
                case (idx_nxt)
                    5'h01:
                    begin
                        seq_ok_r  <= (rx_byte == `MCC_OP_ACTIVATE);
                        rd_mode_r <= (rx_byte == `MCC_OP_RD_BUF);
                    end
                    5'h02: seq_ok_r <= seq_ok_r & (rx_byte == `MCC_OP_SUB_CRC);
                    5'h03:
                    begin
                        scope_rng_r <= (rx_byte == `MCC_SCOPE_RANGE);
                        seq_ok_r    <= seq_ok_r & ((rx_byte == `MCC_SCOPE_ALL) |
                                                   (rx_byte == `MCC_SCOPE_RANGE));
                    end
                    default:
                    begin
                        if (idx_nxt >= `MCC_IDX_EXP_FIRST && idx_nxt <= `MCC_IDX_EXP_LAST)
                            exp_r <= {rx_byte, exp_r[63:8]};
                        if (idx_nxt >= `MCC_IDX_STA_FIRST && idx_nxt <= `MCC_IDX_STA_LAST)
                            sta_r <= {rx_byte, sta_r[23:8]};
                        if (idx_nxt >= `MCC_IDX_END_FIRST && idx_nxt <= `MCC_IDX_END_LAST)
                            end_r <= {rx_byte, end_r[23:8]};
                    end
                endcase
                // next read-buffer byte, low location first, zero past the end
                if (rd_mode_r | (idx_nxt == 5'h01 && rx_byte == `MCC_OP_RD_BUF))
                begin
                    tx_sh_r  <= buf_byte;
                    rd_loc_r <= loc_nxt;
                end
            end
        end
    end

    // serial output: msb of the loaded byte after each falling clock
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spi_so_r      <= 1'b0;
            spi_so_oe_n_r <= 1'b1;
        end
        else
        begin
            spi_so_oe_n_r <= ~(rd_mode_r & ~cs_n_s);
            if (sck_fall)
                spi_so_r <= tx_sh_r[7];
        end
    end

    // ************************************************
    // check engine
    // ************************************************
    reg  [3:0]  state_r;
    reg  [63:0] crc_r;
    reg  [23:0] last_r;
    wire        start = cs_rise & seq_full & ~busy_r & ~eng_rst;
    wire [63:0] crc_final = ~crc_r;
    wire        fail = (crc_final != exp_r);

    // walk the array, then compare and post the result
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r       <= ST_IDLE;
            crc_r         <= `MCC_CRC_SEED;
            last_r        <= 24'h0;
            buf_r         <= 64'h0;
            mem_rd_r      <= 1'b0;
            mem_addr_r    <= 24'h0;
            mem_die_r     <= 2'h0;
            flag_status_r <= 8'h00;
            int_status_r  <= 8'h00;
            irq_r         <= 1'b0;
            busy_r        <= 1'b0;
        end
        else if (eng_rst)
        begin
            // hardware and software reset abort and clear; sig_rst does not
            state_r       <= ST_IDLE;
            buf_r         <= 64'h0;
            mem_rd_r      <= 1'b0;
            flag_status_r <= 8'h00;
            int_status_r  <= 8'h00;
            irq_r         <= 1'b0;
            busy_r        <= 1'b0;
        end
        else
        begin
            irq_r <= int_status_r[`MCC_ISR_DONE_BIT] & ~int_mask[`MCC_ISR_DONE_BIT];
            case (state_r)
                ST_IDLE:
                begin
                    if (done_clr)
                        int_status_r[`MCC_ISR_DONE_BIT] <= 1'b0;
                    if (start)
                    begin
                        buf_r      <= 64'h0;
                        crc_r      <= `MCC_CRC_SEED;
                        mem_die_r  <= die_sel;
                        mem_addr_r <= scope_rng_r ? sta_r : `MCC_ADDR_FIRST;
                        last_r     <= ~scope_rng_r ? `MCC_ADDR_LAST :
                                      (end_r < sta_r) ? sta_r : end_r;
                        int_status_r[`MCC_ISR_DONE_BIT] <= 1'b0;
                        busy_r     <= 1'b1;
                        mem_rd_r   <= 1'b1;
                        state_r    <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    if (mem_ack)
                    begin
                        crc_r    <= crc_byte(crc_r, mem_rdata);
                        mem_rd_r <= 1'b0;
                        state_r  <= (mem_addr_r == last_r) ? ST_FIN : ST_GAP;
                    end
                end
                ST_GAP:
                begin
                    mem_addr_r <= mem_addr_r + 24'h000001;
                    mem_rd_r   <= 1'b1;
                    state_r    <= ST_READ;
                end
                ST_FIN:
                begin
                    if (fail)
                        buf_r <= crc_final;
                    // result and completion land in one cycle
                    flag_status_r[`MCC_FSR_FAIL_BIT] <= fail;
                    int_status_r[`MCC_ISR_DONE_BIT]  <= 1'b1;
                    busy_r  <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- mcc_crc_engine_props.sv
// checker for the crc check engine: array handshake, flags, interrupt
// assumes binding onto mcc_crc_engine, one clk_sys domain
`timescale 1ns/1ns
`default_nettype none
module mcc_crc_engine_props
(
    input wire        clk_sys,
    input wire        rst_n,
    input wire        soft_rst,
    input wire        sig_rst,
    input wire        spi_cs_n,
    input wire [1:0]  die_sel,
    input wire        mem_rd_r,
    input wire [23:0] mem_addr_r,
    input wire [1:0]  mem_die_r,
    input wire        mem_ack,
    input wire [7:0]  int_mask,
    input wire [7:0]  flag_status_r,
    input wire [7:0]  int_status_r,
    input wire        irq_r,
    input wire        busy_r,
    input wire        spi_so_oe_n_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n || soft_rst);
    // ****************************************
    // assertions
    // ****************************************
    a_done_ends_busy: assert property ($rose(int_status_r[1]) |-> $fell(busy_r))
        else $error("done flag rose without end of check");
    a_done_low_run: assert property (busy_r && $past(busy_r) |-> !int_status_r[1])
        else $error("done flag high while check runs");
    a_flag_only_bit: assert property ((flag_status_r & 8'hf7) == 8'h00)
        else $error("flag status spare bit set");
    a_irq_follows: assert property (int_status_r[1] && !int_mask[1] |=> irq_r)
        else $error("unmasked completion gave no irq");
    a_irq_masked: assert property (int_mask[1] |=> !irq_r)
        else $error("masked completion raised irq");
    a_rd_holds: assert property (mem_rd_r && !mem_ack |=> mem_rd_r && $stable(mem_addr_r))
        else $error("read request dropped before ack");
    a_rd_gap: assert property (mem_ack |=> !mem_rd_r)
        else $error("no idle cycle after ack");
    a_addr_step: assert property (mem_ack ##2 mem_rd_r |-> mem_addr_r == $past(mem_addr_r, 2) + 24'h1)
        else $error("walk address did not step by one");
    a_sig_keeps: assert property (sig_rst && mem_rd_r && !mem_ack |=> busy_r)
        else $error("signalling reset aborted check");
    a_die_walk: assert property (mem_rd_r |-> mem_die_r == die_sel)
        else $error("walk die differs from selected die");
    a_start_cs_high: assert property ($rose(busy_r) |-> spi_cs_n)
        else $error("check started with chip select low");
    a_oe_idle: assert property (spi_cs_n [*6] |-> spi_so_oe_n_r)
        else $error("output driven while deselected");
endmodule
bind mcc_crc_engine mcc_crc_engine_props u_props
(
    .clk_sys(clk_sys), .rst_n(rst_n), .soft_rst(soft_rst), .sig_rst(sig_rst),
    .spi_cs_n(spi_cs_n), .die_sel(die_sel), .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r),
    .mem_die_r(mem_die_r), .mem_ack(mem_ack), .int_mask(int_mask),
    .flag_status_r(flag_status_r), .int_status_r(int_status_r), .irq_r(irq_r),
    .busy_r(busy_r), .spi_so_oe_n_r(spi_so_oe_n_r)
);
`default_nettype wire

//--- mcc_array_model.sv
// array model: answers each read after a short or long latency
// assumes the engine's one-outstanding read handshake on clk_sys
`timescale 1ns/1ns
`default_nettype none
module mcc_array_model
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        mem_rd_r,
    input  wire logic [23:0] mem_addr_r,
    input  wire logic [1:0]  mem_die_r,
    output var  logic        mem_ack,
    output var  logic [7:0]  mem_rdata
);
    logic [2:0] wait_r;
    // count latency, pulse ack with address-derived byte
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_r    <= 3'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= 8'h00;
        end
        else
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata; // inverted every cycle between answers
            if (mem_rd_r && !mem_ack && wait_r >= {slow, 2'b01})
            begin
                mem_ack   <= 1'b1;
                mem_rdata <= mem_addr_r[7:0] ^ {6'h00, mem_die_r};
                wait_r    <= 3'h0;
            end
            else if (mem_rd_r && !mem_ack)
                wait_r <= wait_r + 3'h1;
        end
    end
endmodule
`default_nettype wire

//--- mcc_crc_engine_bench.sv
// testbench for the crc check engine: serial host tasks and checks
// assumes mcc_crc_engine and mcc_array_model; sck period 160 ns
`timescale 1ns/1ns
`default_nettype none
`include "mcc_defines.vh"
module mcc_crc_engine_bench;
    logic clk_sys = 0, rst_n = 0, hw_rst_pin_n = 1, soft_rst = 0, sig_rst = 0;
    logic spi_cs_n = 1, spi_sck = 0, spi_si = 0, done_clr = 0, slow = 0;
    logic [1:0] die_sel = 2'h0;
    logic [7:0] int_mask = 8'h00;
    wire so, oe_n, rd, ack, irq, busy;
    wire [23:0] addr;
    wire [1:0]  mdie;
    wire [7:0]  rdata, fsr, isr;
    wire        so_line = oe_n ? 1'b1 : so; // pull-up on the released data line
    integer n_tests = 0, bad_count = 0;
    // ****************************************
    // clock and instances
    // ****************************************
    always #10 clk_sys = ~clk_sys;
    mcc_crc_engine DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hw_rst_pin_n(hw_rst_pin_n),
        .soft_rst(soft_rst), .sig_rst(sig_rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_si(spi_si), .spi_so_r(so), .spi_so_oe_n_r(oe_n), .die_sel(die_sel),
        .mem_rd_r(rd), .mem_addr_r(addr), .mem_die_r(mdie), .mem_ack(ack),
        .mem_rdata(rdata), .int_mask(int_mask), .done_clr(done_clr),
        .flag_status_r(fsr), .int_status_r(isr), .irq_r(irq), .busy_r(busy));
    mcc_array_model u_array (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .mem_rd_r(rd),
        .mem_addr_r(addr), .mem_die_r(mdie), .mem_ack(ack), .mem_rdata(rdata));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s exp %h got %h", nm, exp, got);
            bad_count++;
        end
    endtask
    function automatic logic [63:0] crc_of(input logic [23:0] s, e, input logic [1:0] d);
        logic [63:0] c;
        logic [23:0] a;
        integer k;
        c = `MCC_CRC_SEED;
        for (a = s; a <= e; a++)
        begin
            c = c ^ {56'h0, a[7:0] ^ {6'h00, d}};
            for (k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ `MCC_CRC_POLY_REF : c >> 1;
        end
        return ~c;
    endfunction
    // one byte each way, msb first, sampled just before sck rises
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        integer i;
        for (i = 7; i >= 0; i--)
        begin
            spi_si <= b[i];
            repeat (4) @(posedge clk_sys);
            r[i] = so_line;
            spi_sck <= 1'b1;
            repeat (4) @(posedge clk_sys);
            spi_sck <= 1'b0;
        end
    endtask
    task automatic wait_busy(input logic want);
        integer t;
        for (t = 0; t < 3000 && busy !== want; t++)
            @(posedge clk_sys);
        if (busy !== want)
        begin
            $display("unexpected busy exp %0d got %0d", want, busy);
            bad_count++;
            summarize();
        end
    endtask
    task automatic send(input logic [7:0] sc, input logic [63:0] x, input logic [23:0] s, e,
        input integer n);
        logic [7:0] b [0:18];
        logic [7:0] r;
        integer i;
        b[0] = 8'h9b;
        b[1] = 8'h27;
        b[2] = sc;
        for (i = 0; i < 8; i++) b[3+i] = x[8*i +: 8];
        for (i = 0; i < 4; i++) b[11+i] = 8'({8'h00, s} >> (8*i));
        for (i = 0; i < 4; i++) b[15+i] = 8'({8'h00, e} >> (8*i));
        spi_cs_n <= 1'b0;
        for (i = 0; i < n; i++) xfer(b[i], r);
        repeat (4) @(posedge clk_sys);
        spi_cs_n <= 1'b1;
        spi_si   <= ~spi_si;
        // return just after a started check raises busy, before a short walk ends
        repeat (4) @(posedge clk_sys);
    endtask
    // full range check with a signalling reset in mid-walk
    task automatic run(input logic [63:0] x, input logic [23:0] s, e);
        send(`MCC_SCOPE_RANGE, x, s, e, 19);
        wait_busy(1'b1);
        sig_rst <= 1'b1;
        @(posedge clk_sys);
        sig_rst <= 1'b0;
        wait_busy(1'b0);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic rdbuf(input logic [63:0] exp);
        logic [7:0] r;
        integer k;
        spi_cs_n <= 1'b0;
        xfer(`MCC_OP_RD_BUF, r);
        for (k = 0; k < 66; k++)
        begin
            xfer(8'h00, r);
            chk("buffer byte", 64'(r), k < 8 ? 64'(exp >> (8*k)) & 64'hff : 64'h0);
        end
        spi_cs_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_fail;
        logic [63:0] c;
        die_sel  <= 2'h2;
        int_mask <= 8'h02;
        slow     <= 1'b1;
        c = crc_of(24'h0000fe, 24'h000101, 2'h2);
        run(c ^ 64'h1, 24'h0000fe, 24'h000101);
        chk("fail flag", 64'(fsr), 64'h8);
        chk("done flag", 64'(isr), 64'h2);
        chk("masked irq", 64'(irq), 64'h0);
        rdbuf(c);
        $display("test fail done");
    endtask
    task automatic t_pass;
        die_sel  <= 2'h0;
        int_mask <= 8'h00;
        slow     <= 1'b0;
        run(crc_of(24'h000010, 24'h000010, 2'h0), 24'h000010, 24'h000010);
        chk("pass flag", 64'(fsr), 64'h0);
        chk("irq", 64'(irq), 64'h1);
        rdbuf(64'h0);
        done_clr <= 1'b1;
        @(posedge clk_sys);
        done_clr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("done cleared", 64'(isr), 64'h0);
        $display("test pass done");
    endtask
    task automatic t_short;
        send(`MCC_SCOPE_RANGE, 64'h0, 24'h0, 24'h5, 15);
        chk("short busy", 64'(busy), 64'h0);
        repeat (30) @(posedge clk_sys);
        chk("short done", 64'(isr), 64'h0);
        $display("test short done");
    endtask
    task automatic t_whole;
        send(`MCC_SCOPE_ALL, 64'h0, 24'h0, 24'h0, 11);
        wait_busy(1'b1);
        chk("whole first addr", 64'(addr), 64'(`MCC_ADDR_FIRST));
        soft_rst <= 1'b1;
        @(posedge clk_sys);
        soft_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("aborted busy", 64'(busy), 64'h0);
        $display("test whole done");
    endtask
    task automatic t_hw;
        hw_rst_pin_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        hw_rst_pin_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rdbuf(64'h0);
        $display("test hw done");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_fail();
        t_pass();
        t_short();
        t_whole();
        t_fail();
        t_hw();
        summarize();
    end
endmodule
`default_nettype wire
